// ===== hw/ssm_map.svh
// Register offsets, field positions, reset values and timing for the speed monitor.
`ifndef SSM_MAP_SVH
`define SSM_MAP_SVH
`define SSM_REG_CTRL 5'h00
`define SSM_REG_ZERO 5'h01
`define SSM_REG_HYST 5'h02
`define SSM_REG_GEAR 5'h03
`define SSM_REG_RES1 5'h04
`define SSM_REG_RES2 5'h05
`define SSM_REG_PITCH 5'h06
`define SSM_REG_STATUS 5'h07
`define SSM_REG_COUNT1 5'h08
`define SSM_REG_COUNT2 5'h09
`define SSM_REG_THR0 5'h10
`define SSM_CTRL_AXIS_LIN 0
`define SSM_CTRL_SENS_LIN 1
`define SSM_CTRL_DEV_LO 2
`define SSM_CTRL_DIR_EN 5
`define SSM_CTRL_QUAL_LO 6
`define SSM_CTRL_NTHR_LO 8
`define SSM_CTRL_PROX_LO 12
`define SSM_CTRL_RST 32'h0000_0100
`define SSM_HYST_RST 16'h0005
`define SSM_GEAR_RST 16'h0001
`define SSM_RES_RST 16'h0001
`define SSM_PITCH_RST 16'h0001
`define SSM_LIM_RST 16'h0000
`define SSM_SEC_PER_MIN 64'h0000_0000_0000_003C
`define SSM_MILLI 64'h0000_0000_0000_03E8
`define SSM_PCT 72'h00_0000_0000_0000_0064
`define SSM_CLK_HZ 64'h0000_0000_02FA_F080
`define SSM_GATE_MS 16'h0064
`endif

// ===== hw/ssm_pkg.sv
// Types shared by the speed monitor.
package ssm_pkg;
  typedef enum logic [2:0] {
    SSM_DEV_ENC, SSM_DEV_PROX, SSM_DEV_ENC_PROX, SSM_DEV_PROX_PROX, SSM_DEV_ENC_ENC
  } ssm_dev_t;
  typedef enum logic [1:0] {SSM_QUAL_BOTH, SSM_QUAL_CW, SSM_QUAL_CCW} ssm_qual_t;
  typedef enum logic [3:0] {
    SSM_PX_NONE, SSM_PX_PNP3_NC, SSM_PX_PNP3_NO, SSM_PX_NPN3_NO, SSM_PX_NPN3_NC,
    SSM_PX_PNP4_NCNO, SSM_PX_NPN4_NCNO, SSM_PX_PN4_NCNC, SSM_PX_PN4_NONO
  } ssm_prox_t;
endpackage : ssm_pkg

// ===== hw/ssm_monitor.sv
// Standstill and overspeed monitor with an Avalon-MM register slave.
`timescale 1ns/1ns
`include "ssm_map.svh"

// Notes on behaviour
// R1 - Standstill flag is 1 below the zero-speed limit, 0 above it.
// R2 - Overspeed-ok is 1 below the selected threshold, 0 once exceeded.
// R3 - Direction output is 1 counterclockwise, 0 clockwise.
// R4 - Direction output only drives when direction enable is set.
// R5 - Bidirectional qualifier detects excess in either rotation direction.
// R6 - CW or CCW qualifier detects excess only in that direction.
// R7 - One to eight thresholds can be configured.
// R8 - With several thresholds, select pins choose the active one.
// R9 - Two thresholds use select 0; up to four use selects 1:0.
// R10 - Up to eight thresholds use selects 2:0 as binary index.
// R11 - Percentage hysteresis stops small speed changes toggling outputs.
// R12 - Gear ratio scales second sensor against first when two exist.
// R13 - Five sensor arrangements: encoder, proximity, mixed, two proximity, two encoders.
// R14 - Resolution held per sensor as pulses per rev or micrometres per pulse.
// R15 - Rotary axis: frequency equals rpm over 60 times resolution.
// R16 - Linear axis, rotary sensor: speed times 1000 over 60 times pitch.
// R17 - Linear axis, linear sensor: speed times 1000 over resolution.
// R18 - Proximity polarity follows PNP or NPN, NO or NC type.
// R19 - Linear axis converts sensor revolutions to distance by pitch.
// R20 - Rotary or linear sensor choice applies only on a linear axis.
// R21 - Pulses counted over a fixed gate; flags update once per gate.
// R22 - Flag reasserts only after speed moves back by the hysteresis, or for overspeed-ok when the qualifier stops matching.
module ssm_monitor
  import ssm_pkg::*;
#(
  parameter int GATE_CYCLES = 5000000,
  parameter int CNT_W = 24
) (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic resetn_in,
  // Avalon-MM slave.
  input wire logic [4:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // Sensor pins.
  input wire logic s1_a_in,
  input wire logic s1_b_in,
  input wire logic s2_a_in,
  input wire logic s2_b_in,
  // Threshold select pins.
  input wire logic threshold_select_0,
  input wire logic threshold_select_1,
  input wire logic threshold_select_2,
  // Flags.
  output logic standstill_out,
  output logic overspeed_ok_out,
  output logic direction_out,
  output logic direction_valid_out
);

  logic [31:0] ctrl_q;
  logic [15:0] zero_q, hyst_q, gear_q, res1_q, res2_q, pitch_q;
  logic [15:0] thr_q [8];
  logic [6:0] sync1_q, sync2_q;
  logic [2:0] prime_q;
  logic s1a_prev_q, s2a_prev_q;
  logic [CNT_W-1:0] cnt1_q, cnt2_q, meas1_q, meas2_q;
  logic [31:0] gate_q;
  logic gate_tick_q, eval_q, dir_q, mismatch_q;
  logic [2:0] sel_idx;

  wire logic axis_lin = ctrl_q[`SSM_CTRL_AXIS_LIN];
  wire logic sens_lin = ctrl_q[`SSM_CTRL_SENS_LIN];
  wire ssm_dev_t dev = ssm_dev_t'(ctrl_q[`SSM_CTRL_DEV_LO +: 3]);
  wire ssm_qual_t qual = ssm_qual_t'(ctrl_q[`SSM_CTRL_QUAL_LO +: 2]);
  wire ssm_prox_t ptype = ssm_prox_t'(ctrl_q[`SSM_CTRL_PROX_LO +: 4]);
  wire logic [3:0] nthr = ctrl_q[`SSM_CTRL_NTHR_LO +: 4];

  // NPN pulls low when active and NC opens when active; either inverts the sense.
  function automatic logic prox_invert(input ssm_prox_t t);
    unique case (t)
      SSM_PX_PNP3_NC, SSM_PX_NPN3_NO, SSM_PX_PNP4_NCNO, SSM_PX_PN4_NCNC: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : prox_invert

  // R9 two selects
  // R10 three selects
  function automatic logic [2:0] thr_index(input logic [3:0] n, input logic [2:0] s);
    logic [2:0] idx;
    idx = 3'h0;
    if (n <= 4'h1) begin
      idx = 3'h0;
    end else if (n == 4'h2) begin
      idx = {2'b00, s[0]};
    end else if (n <= 4'h4) begin
      idx = {1'b0, s[1:0]};
    end else begin
      idx = s;
    end
    if ({1'b0, idx} >= n && n != 4'h0) begin
      idx = 3'(n - 4'h1);
    end
    return idx;
  endfunction : thr_index

  // Two-stage synchronisers on every pin; stage one feeds only stage two.
  logic [6:0] pins_raw;
  assign pins_raw = {threshold_select_2, threshold_select_1, threshold_select_0,
                     s2_b_in, s2_a_in, s1_b_in, s1_a_in};
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      sync1_q <= 7'h00;
      sync2_q <= 7'h00;
      prime_q <= 3'h0;
    end else begin
      sync1_q <= pins_raw;
      sync2_q <= sync1_q;
      prime_q <= {prime_q[1:0], 1'b1};
    end
  end

  // R13 arrangement decode
  wire logic s1_is_enc = (dev == SSM_DEV_ENC) || (dev == SSM_DEV_ENC_PROX) ||
                         (dev == SSM_DEV_ENC_ENC);
  wire logic s2_used = (dev == SSM_DEV_ENC_PROX) || (dev == SSM_DEV_PROX_PROX) ||
                       (dev == SSM_DEV_ENC_ENC);
  wire logic s2_is_enc = (dev == SSM_DEV_ENC_ENC);
  // R18 proximity polarity
  wire logic s1a = sync2_q[0] ^ (!s1_is_enc && prox_invert(ptype));
  wire logic s2a = sync2_q[2] ^ (!s2_is_enc && prox_invert(ptype));
  // Edges count only once the previous-level register holds a live pin level.
  // A sensor that rests high would otherwise add one false pulse after reset.
  wire logic s1_edge = s1a && !s1a_prev_q && prime_q[2];
  wire logic s2_edge = s2a && !s2a_prev_q && s2_used && prime_q[2];
  assign sel_idx = thr_index(nthr, sync2_q[6:4]);

  // R21 gate timer
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      gate_q <= 32'h0000_0000;
      gate_tick_q <= 1'b0;
    end else if (gate_q == 32'(GATE_CYCLES - 1)) begin
      gate_q <= 32'h0000_0000;
      gate_tick_q <= 1'b1;
    end else begin
      gate_q <= gate_q + 32'h0000_0001;
      gate_tick_q <= 1'b0;
    end
  end

  // R21 pulse counting
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      s1a_prev_q <= 1'b0;
      s2a_prev_q <= 1'b0;
      cnt1_q <= '0;
      cnt2_q <= '0;
      meas1_q <= '0;
      meas2_q <= '0;
      eval_q <= 1'b0;
    end else begin
      s1a_prev_q <= s1a;
      s2a_prev_q <= s2a;
      eval_q <= gate_tick_q;
      if (gate_tick_q) begin
        meas1_q <= cnt1_q;
        meas2_q <= cnt2_q;
        cnt1_q <= CNT_W'(s1_edge);
        cnt2_q <= CNT_W'(s2_edge);
      end else begin
        if (s1_edge && cnt1_q != '1) cnt1_q <= cnt1_q + 1'b1;
        if (s2_edge && cnt2_q != '1) cnt2_q <= cnt2_q + 1'b1;
      end
    end
  end

  // R3 quadrature direction
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      dir_q <= 1'b0;
    end else if (s1_is_enc && s1_edge) begin
      dir_q <= sync2_q[1];
    end else if (!s1_is_enc && s2_is_enc && s2_edge) begin
      dir_q <= sync2_q[3];
    end
  end

  // R15 rotary axis scaling
  // R16 linear axis with rotary sensor
  // R17 linear sensor scaling
  // R19 pitch conversion
  // R20 sensor type on linear axis
  logic [63:0] meas_k, lim_k;
  always_comb begin
    if (!axis_lin) begin
      meas_k = `SSM_MILLI * `SSM_SEC_PER_MIN;
      lim_k = 64'(`SSM_GATE_MS) * 64'(res1_q);
    end else if (!sens_lin) begin
      meas_k = `SSM_MILLI * `SSM_SEC_PER_MIN * 64'(pitch_q);
      lim_k = `SSM_MILLI * 64'(`SSM_GATE_MS) * 64'(res1_q);
    end else begin
      meas_k = `SSM_MILLI * 64'(res1_q);
      lim_k = `SSM_MILLI * 64'(`SSM_GATE_MS);
    end
  end

  // Limits scale by the gate length in microseconds and the speed by a thousand.
  // A gate that is not a whole number of milliseconds then still compares in real units.
  wire logic [63:0] gate_us_k = (64'(GATE_CYCLES) * `SSM_MILLI * `SSM_MILLI) / `SSM_CLK_HZ;
  wire logic [63:0] lim_adj = (lim_k / 64'(`SSM_GATE_MS)) * gate_us_k;
  wire logic [71:0] speed_v = 72'(meas1_q) * 72'(meas_k) * 72'(`SSM_MILLI);
  wire logic [71:0] zero_v = 72'(64'(zero_q) * lim_adj);
  wire logic [71:0] thr_v = 72'(64'(thr_q[sel_idx]) * lim_adj);
  wire logic [71:0] back_pct = `SSM_PCT - 72'(hyst_q);
  // R5 bidirectional
  // R6 direction qualified
  wire logic dir_match = (qual == SSM_QUAL_BOTH) || (qual == SSM_QUAL_CW && !dir_q) ||
                         (qual == SSM_QUAL_CCW && dir_q);

  // R12 gear ratio check
  wire logic [63:0] v1 = 64'(meas1_q) * 64'(gear_q) * 64'(res2_q);
  wire logic [63:0] v2 = 64'(meas2_q) * 64'(res1_q);
  wire logic [63:0] vdiff = (v1 > v2) ? (v1 - v2) : (v2 - v1);

  // R1 standstill
  // R11 hysteresis
  // R22 reassert after band
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      standstill_out <= 1'b1;
    end else if (eval_q) begin
      if (speed_v > zero_v) begin
        standstill_out <= 1'b0;
      end else if (speed_v * `SSM_PCT < zero_v * back_pct) begin
        standstill_out <= 1'b1;
      end
    end
  end

  // R2 overspeed
  // R11 hysteresis
  // R22 reassert after band
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      overspeed_ok_out <= 1'b1;
    end else if (eval_q) begin
      if (speed_v > thr_v && dir_match) begin
        overspeed_ok_out <= 1'b0;
      end else if (speed_v * `SSM_PCT < thr_v * back_pct || !dir_match) begin
        overspeed_ok_out <= 1'b1;
      end
    end
  end

  // R4 direction gating
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      direction_out <= 1'b0;
      direction_valid_out <= 1'b0;
      mismatch_q <= 1'b0;
    end else begin
      direction_out <= ctrl_q[`SSM_CTRL_DIR_EN] && dir_q;
      direction_valid_out <= ctrl_q[`SSM_CTRL_DIR_EN];
      if (eval_q) mismatch_q <= s2_used && (vdiff > (v2 >> 3));
    end
  end

  // Every request waits one cycle, then waitrequest is low for exactly one cycle.
  wire logic req = avs_read_in || avs_write_in;
  wire logic commit = avs_write_in && !avs_waitrequest_out;
  wire logic [4:0] a = avs_address_in;
  logic [31:0] rd_v;
  always_comb begin
    rd_v = 32'h0000_0000;
    unique case (a)
      `SSM_REG_CTRL: rd_v = ctrl_q;
      `SSM_REG_ZERO: rd_v = {16'h0000, zero_q};
      `SSM_REG_HYST: rd_v = {16'h0000, hyst_q};
      `SSM_REG_GEAR: rd_v = {16'h0000, gear_q};
      `SSM_REG_RES1: rd_v = {16'h0000, res1_q};
      `SSM_REG_RES2: rd_v = {16'h0000, res2_q};
      `SSM_REG_PITCH: rd_v = {16'h0000, pitch_q};
      `SSM_REG_STATUS: rd_v = {24'h00_0000, sel_idx, mismatch_q, dir_q,
                               direction_out, overspeed_ok_out, standstill_out};
      `SSM_REG_COUNT1: rd_v = 32'(meas1_q);
      `SSM_REG_COUNT2: rd_v = 32'(meas2_q);
      default: rd_v = (a[4:3] == 2'b10) ? {16'h0000, thr_q[a[2:0]]} : 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out <= 32'h0000_0000;
    end else begin
      avs_waitrequest_out <= !(req && avs_waitrequest_out);
      if (avs_read_in && avs_waitrequest_out) avs_readdata_out <= rd_v;
    end
  end

  // R7 threshold count
  // R14 per-sensor resolution
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      ctrl_q <= `SSM_CTRL_RST;
      zero_q <= `SSM_LIM_RST;
      hyst_q <= `SSM_HYST_RST;
      gear_q <= `SSM_GEAR_RST;
      res1_q <= `SSM_RES_RST;
      res2_q <= `SSM_RES_RST;
      pitch_q <= `SSM_PITCH_RST;
    end else if (commit) begin
      unique case (a)
        `SSM_REG_CTRL: begin
          ctrl_q <= avs_writedata_in;
          if (avs_writedata_in[`SSM_CTRL_NTHR_LO +: 4] == 4'h0) ctrl_q[11:8] <= 4'h1;
          if (avs_writedata_in[`SSM_CTRL_NTHR_LO +: 4] > 4'h8) ctrl_q[11:8] <= 4'h8;
        end
        `SSM_REG_ZERO: zero_q <= avs_writedata_in[15:0];
        `SSM_REG_HYST: hyst_q <= (avs_writedata_in[15:0] > 16'h0063) ? 16'h0063 :
                                 avs_writedata_in[15:0];
        `SSM_REG_GEAR: gear_q <= avs_writedata_in[15:0];
        `SSM_REG_RES1: res1_q <= avs_writedata_in[15:0];
        `SSM_REG_RES2: res2_q <= avs_writedata_in[15:0];
        `SSM_REG_PITCH: pitch_q <= avs_writedata_in[15:0];
        default: ;
      endcase
    end
  end

  // R8 threshold storage
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_thr
      always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
          thr_q[gi] <= `SSM_LIM_RST;
        end else if (commit && a == (`SSM_REG_THR0 + 5'(gi))) begin
          thr_q[gi] <= avs_writedata_in[15:0];
        end
      end
    end
  endgenerate

  // R1 check standstill
  standstill_drop_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    eval_q && speed_v > zero_v |=> !standstill_out) else $error("standstill not cleared"); // R1
  // R2 check overspeed
  overspeed_drop_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    eval_q && speed_v > thr_v && dir_match |=> !overspeed_ok_out)
    else $error("overspeed not flagged"); // R2
  // R6 check qualifier
  qualifier_mask_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    eval_q && !dir_match |=> overspeed_ok_out) else $error("wrong direction flagged"); // R6
  // R4 check direction gating
  dir_gate_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    !direction_valid_out |-> !direction_out) else $error("direction without enable"); // R4
  // R21 check flag timing
  flag_hold_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    !eval_q |=> $stable(standstill_out) && $stable(overspeed_ok_out))
    else $error("flag moved off gate"); // R21
  // R22 check hysteresis band
  hyst_band_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    eval_q && !standstill_out && speed_v <= zero_v && speed_v * `SSM_PCT >= zero_v * back_pct
    |=> !standstill_out) else $error("standstill chattered"); // R22
  // R10 check select range
  select_range_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    nthr != 4'h0 |-> {1'b0, sel_idx} < nthr) else $error("select beyond count"); // R10
  // R7 check count range
  count_range_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    nthr >= 4'h1 && nthr <= 4'h8) else $error("threshold count out of range"); // R7
  bus_answer_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    req && avs_waitrequest_out |=> !avs_waitrequest_out ##1 avs_waitrequest_out)
    else $error("bus answer late");
  standstill_cov: cover property (@(posedge clk_in) disable iff (!resetn_in)
    $fell(standstill_out));
  overspeed_cov: cover property (@(posedge clk_in) disable iff (!resetn_in)
    $fell(overspeed_ok_out));
  recover_cov: cover property (@(posedge clk_in) disable iff (!resetn_in)
    $rose(overspeed_ok_out));
  ccw_cov: cover property (@(posedge clk_in) disable iff (!resetn_in) $rose(direction_out));

endmodule : ssm_monitor

// ===== test/ssm_sensor_model.sv
// Quadrature encoder on the monitored axis.
`timescale 1ns/1ns
module ssm_sensor_model (
  // Clock.
  input wire logic clk_in,
  // Motion control.
  input wire logic run_in,
  input wire logic ccw_in,
  input wire logic [15:0] period_in,
  // Encoder channels.
  output logic a_out,
  output logic b_out
);
  logic [15:0] ph_q = 16'h0000;
  logic [15:0] qtr;

  // The shaft holds its last position while stopped; A keeps its level, and B keeps it unless ccw_in changes.
  always_ff @(posedge clk_in) begin
    if (run_in) begin
      ph_q <= (ph_q >= period_in - 16'h0001) ? 16'h0000 : ph_q + 16'h0001;
    end
  end

  assign qtr = period_in >> 2;
  assign a_out = ph_q < (period_in >> 1);
  assign b_out = ccw_in ^ ((ph_q >= qtr) && (ph_q < 16'h0003 * qtr));
endmodule : ssm_sensor_model

// ===== test/standstill_overspeed_monitor_tb.sv
// Self-checking bench for the standstill and overspeed monitor.
`timescale 1ns/1ns
`include "ssm_map.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin bad_count++; \
  $display("BAD %0t got %h exp %h", $time, (g), (e)); end end
module standstill_overspeed_monitor_tb;
  import ssm_pkg::*;
  localparam int G = 15000;
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [4:0] adr = 5'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0000_0000;
  logic [31:0] rdq;
  logic [31:0] rdat;
  logic wait_r;
  logic s1a;
  logic s1b;
  logic s2a;
  logic s2b;
  int zl = 1000;
  logic [2:0] sel = 3'h0;
  logic ss;
  logic ok;
  logic dir;
  logic dval;
  logic run = 1'b0;
  logic ccw = 1'b0;
  logic ex_ss = 1'b1;
  logic ex_ok = 1'b1;
  logic [31:0] lfsr = 89859;
  int bad_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  int thr[8];
  int s;

  ssm_monitor #(.GATE_CYCLES(G), .CNT_W(24)) u_dut (
    .clk_in(clk_in), .resetn_in(resetn_in), .avs_address_in(adr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wd), .avs_readdata_out(rdq),
    .avs_waitrequest_out(wait_r), .s1_a_in(s1a), .s1_b_in(s1b), .s2_a_in(s2a),
    .s2_b_in(s2b), .threshold_select_0(sel[0]), .threshold_select_1(sel[1]),
    .threshold_select_2(sel[2]), .standstill_out(ss), .overspeed_ok_out(ok),
    .direction_out(dir), .direction_valid_out(dval));

  ssm_sensor_model u_enc (.clk_in(clk_in), .run_in(run), .ccw_in(ccw),
    .period_in(16'h01F4), .a_out(s1a), .b_out(s1b));

  // Second encoder on the same moving part, for the gear ratio cross-check.
  ssm_sensor_model u_enc2 (.clk_in(clk_in), .run_in(run), .ccw_in(ccw),
    .period_in(16'h01F4), .a_out(s2a), .b_out(s2b));

  initial begin
    forever #10 clk_in = ~clk_in;
  end

  always @(posedge clk_in) begin
    if (resetn_in) cyc <= cyc + 1;
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr_next

  task automatic end_sim();
    $display("mismatches %0d comparisons %0d", bad_count, samples_checked);
    if (bad_count == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_sim

  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_in);
    wr <= w;
    rd <= !w;
    adr <= a;
    wd <= d;
    do begin
      @(posedge clk_in);
      n++;
    end while (wait_r !== 1'b0 && n < 20);
    rdat = rdq;
    wr <= 1'b0;
    rd <= 1'b0;
    if (n >= 20) begin
      bad_count++;
      $display("BAD %0t no bus answer", $time);
    end
  endtask : bus

  task automatic rchk(input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    `CHK(rdat, e)
  endtask : rchk

  // Reference flags for one gate: speed in rpm with 1000 pulses per rev, 15000-cycle (0.3 ms) gate.
  task automatic ev(input int spd, input bit cw, input int q, input int t);
    if (spd > zl) ex_ss = 1'b0;
    else if (spd * 100 < zl * 95) ex_ss = 1'b1;
    if (q != 0 && ((q == 1) != cw)) ex_ok = 1'b1;
    else if (spd > t) ex_ok = 1'b0;
    else if (spd * 100 < t * 95) ex_ok = 1'b1;
  endtask : ev

  task automatic fchk(input logic ed);
    @(negedge clk_in);
    `CHK(ss, ex_ss)
    `CHK(ok, ex_ok)
    `CHK(dir, ed)
    `CHK(dval, 1'b1)
  endtask : fchk

  task automatic upto(input int n);
    while (cyc < n) @(posedge clk_in);
  endtask : upto

  initial begin
    repeat (6 * G) @(posedge clk_in);
    bad_count++;
    $display("BAD %0t watchdog expired", $time);
    end_sim();
  end

  initial begin
    repeat (4) @(posedge clk_in);
    resetn_in <= 1'b1;
    @(negedge clk_in);
    `CHK(wait_r, 1'b1)
    `CHK(ss, 1'b1)
    `CHK(ok, 1'b1)
    `CHK(dval, 1'b0)
    rchk(`SSM_REG_CTRL, `SSM_CTRL_RST);
    rchk(`SSM_REG_HYST, 32'h0000_0005);
    rchk(`SSM_REG_GEAR, 32'h0000_0001);
    rchk(`SSM_REG_RES2, 32'h0000_0001);
    rchk(`SSM_REG_PITCH, 32'h0000_0001);
    bus(1'b1, 5'h1F, 32'hFFFF_FFFF);
    rchk(5'h1F, 32'h0000_0000);
    bus(1'b1, `SSM_REG_RES1, 32'h0000_03E8);
    bus(1'b1, `SSM_REG_ZERO, 32'h0000_03E8);
    bus(1'b1, `SSM_REG_RES2, 32'h0000_03E8);
    for (int i = 0; i < 8; i++) begin
      thr[i] = (i + 1) * 2000 + 500;
      bus(1'b1, `SSM_REG_THR0 + 5'(i), 32'(thr[i]));
    end
    bus(1'b1, `SSM_REG_CTRL, 32'h0000_0830);
    rchk(`SSM_REG_THR0 + 5'h07, 32'(thr[7]));
    lfsr = lfsr_next(lfsr);
    s = int'(lfsr[2:0]);
    sel <= lfsr[2:0];
    ccw <= 1'b1;
    run <= 1'b1;
    upto(3 * G / 2);
    ev(6000, 1'b0, 0, thr[s]);
    fchk(1'b1);
    bus(1'b0, `SSM_REG_STATUS, 32'h0000_0000);
    `CHK(rdat[4], 1'b0)
    // opposite direction ignored; speed inside the band keeps the flag.
    bus(1'b1, `SSM_REG_CTRL, 32'h0000_08B0);
    bus(1'b1, `SSM_REG_GEAR, 32'h0000_0002);
    bus(1'b1, `SSM_REG_ZERO, 32'h0000_17D4);
    zl = 6100;
    ccw <= 1'b0;
    sel <= 3'h0;
    upto(5 * G / 2);
    ev(6000, 1'b1, 2, thr[0]);
    fchk(1'b0);
    bus(1'b0, `SSM_REG_STATUS, 32'h0000_0000);
    `CHK(rdat[4], 1'b1)
    bus(1'b1, `SSM_REG_CTRL, 32'h0000_0870);
    lfsr = lfsr_next(lfsr);
    s = int'(lfsr[2:0]);
    sel <= lfsr[2:0];
    upto(7 * G / 2);
    ev(6000, 1'b1, 1, thr[s]);
    fchk(1'b0);
    bus(1'b0, `SSM_REG_STATUS, 32'h0000_0000);
    `CHK(rdat[7:5], 3'(s))
    run <= 1'b0;
    upto(11 * G / 2);
    ev(0, 1'b1, 1, thr[s]);
    fchk(1'b0);
    end_sim();
  end
endmodule : standstill_overspeed_monitor_tb
